// ### hw/hpdft_pkg.sv
// Purpose: Shared constants and types for the heat-pump defrost timer
// Assumes: Timebase derived from a 25 MHz system clock
// Notes: All defrost times are counted in whole seconds
package hpdft_pkg;
    localparam int CLK_HZ = 25_000_000;
    localparam int TICK_S = 1;
    localparam int TICK_CYCLES = CLK_HZ * TICK_S;

    localparam int TW = 14;
    typedef logic [TW-1:0] hpdft_sec_t;

    localparam int SEC_PER_MIN = 60;
    localparam int INT_A_MIN = 30;
    localparam int INT_B_MIN = 60;
    localparam int INT_C_MIN = 90;
    localparam int INT_D_MIN = 120;
    localparam int START_DELAY_MIN = 5;
    localparam int DFR_MAX_MIN = 10;
    localparam hpdft_sec_t INT_A_S = hpdft_sec_t'(INT_A_MIN * SEC_PER_MIN);
    localparam hpdft_sec_t INT_B_S = hpdft_sec_t'(INT_B_MIN * SEC_PER_MIN);
    localparam hpdft_sec_t INT_C_S = hpdft_sec_t'(INT_C_MIN * SEC_PER_MIN);
    localparam hpdft_sec_t INT_D_S = hpdft_sec_t'(INT_D_MIN * SEC_PER_MIN);
    localparam hpdft_sec_t START_DELAY_S = hpdft_sec_t'(START_DELAY_MIN * SEC_PER_MIN);
    localparam hpdft_sec_t DFR_MAX_S = hpdft_sec_t'(DFR_MAX_MIN * SEC_PER_MIN);
    localparam hpdft_sec_t PAUSE_S = 14'h001e;
    localparam hpdft_sec_t SHORT_DFR_S = 14'h001e;
    localparam hpdft_sec_t FAN_HOLD_S = 14'h0028;
    localparam hpdft_sec_t LONG_PRESS_S = 14'h0005;

    // Register port
    localparam int AW = 2;
    localparam int DW = 16;
    localparam logic [AW-1:0] ADDR_CTRL = 2'h0;
    localparam logic [AW-1:0] ADDR_STATUS = 2'h1;
    localparam logic [AW-1:0] ADDR_RUN = 2'h2;
    localparam int CTRL_FORCE_BIT = 0;
    localparam int CTRL_BYPASS_BIT = 1;

    typedef enum logic [2:0] {
        ST_DELAY = 3'b000,
        ST_HEAT = 3'b001,
        ST_PRE = 3'b010,
        ST_DFR = 3'b011,
        ST_POST = 3'b100
    } hpdft_state_t;
endpackage

// ### hw/hpdft_press.sv
// Purpose: Times a speed-up pin short and classifies it on release
// Assumes: i_tick is a one-cycle pulse once per second
// Notes: Press length has one second of granularity
`timescale 1ns/10ps
`default_nettype none
module hpdft_press (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_tick,
    input wire logic i_short,
    output logic o_bypass,
    output logic o_force
);
    import hpdft_pkg::*;

    hpdft_sec_t held_ff;
    logic short_ff;
    logic release_w;

    assign release_w = short_ff && !i_short;

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            short_ff <= 1'b0;
        end else begin
            short_ff <= i_short;
        end
    end

    // Saturates so a pin left shorted cannot wrap into a bypass
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            held_ff <= '0;
        end else if (!i_short) begin
            held_ff <= '0;
        end else if (i_tick && held_ff < LONG_PRESS_S) begin
            held_ff <= held_ff + 14'h0001;
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_bypass <= 1'b0;
            o_force <= 1'b0;
        end else begin
            o_bypass <= release_w && (held_ff < LONG_PRESS_S);
            o_force <= release_w && (held_ff >= LONG_PRESS_S);
        end
    end

    sequence s_long_release;
        short_ff && !i_short && held_ff >= LONG_PRESS_S;
    endsequence

    AST_LONG_IS_FORCE: assert property (@(posedge i_clk) disable iff (!i_rstn)
        s_long_release |=> o_force && !o_bypass)
        else $error("Long press did not give a forced defrost");

    AST_SHORT_IS_BYPASS: assert property (@(posedge i_clk) disable iff (!i_rstn)
        short_ff && !i_short && held_ff < LONG_PRESS_S |=> o_bypass && !o_force)
        else $error("Brief press did not give a delay bypass");
endmodule // hpdft_press
`default_nettype wire

// ### hw/hpdft_top.sv
// Purpose: Time/temperature defrost controller for a heat-pump outdoor unit
// Assumes: Inputs synchronous to i_clk; coil input high means contacts closed
// Notes: Pause switch covers both the entry/exit pauses and the short cycle
// How it works
// - Interval switches pick 30, 60, 90 or 120 minutes; both off gives 90
// - Five-second speed-up short then release with coil closed forces full defrost
// - Pause option on gives two 30 s compressor-off gaps around each defrost
// - Forced with coil open and pause on: 30 s off, then 30 s defrost
// - Afterwards compressor stays off another 30 s, outdoor fan 40 s
// - Forced with coil open and pause off: only a 30 s defrost
// - A full defrost ends when coil contacts reopen or the cycle time runs out; a short one ends on time only
// - A normal defrost never exceeds 10 minutes
// - In defrost, aux heat and reversing valve are both energised
// - Third switch on stops the compressor 30 s entering and leaving defrost
// - Compressor is held off for 5 minutes after power-up
// - A brief speed-up short, on release, cancels the startup delay
// - A short held 5 s or more requests defrost instead of bypass
`timescale 1ns/10ps
`default_nettype none
module hpdft_top #(
    parameter int TICK_CYCLES = hpdft_pkg::TICK_CYCLES
) (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_heat_call,
    input wire logic i_coil_thermostat_input,
    input wire logic i_speedup_pins,
    input wire logic i_interval_select_lo,
    input wire logic i_interval_select_hi,
    input wire logic i_compressor_pause_switch,
    input wire logic [hpdft_pkg::AW-1:0] i_addr,
    input wire logic [hpdft_pkg::DW-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [hpdft_pkg::DW-1:0] o_rdata,
    output logic o_compressor,
    output logic o_outdoor_fan_output,
    output logic o_aux_heat_output,
    output logic o_reversing_valve
);
    import hpdft_pkg::*;

    localparam int PW = $clog2(TICK_CYCLES + 1);
    localparam logic [PW-1:0] PRE_LAST = PW'(TICK_CYCLES - 1);

    logic rst_meta_ff;
    logic rstn_ff;
    logic [PW-1:0] pre_ff;
    logic tick_ff;
    logic pin_bypass;
    logic pin_force;
    logic sw_force_ff;
    logic sw_bypass_ff;
    logic force_req;
    logic bypass_req;
    hpdft_state_t state_ff;
    hpdft_state_t nxt_state;
    hpdft_sec_t tmr_ff;
    hpdft_sec_t run_ff;
    hpdft_sec_t fan_ff;
    hpdft_sec_t interval;
    hpdft_sec_t dfr_limit;
    logic short_ff;
    logic nxt_short;
    logic interval_due;

    default clocking @(posedge i_clk); endclocking
    default disable iff (!rstn_ff);

    // Release-synchronised reset; everything else uses rstn_ff
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            rst_meta_ff <= 1'b0;
            rstn_ff <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rstn_ff <= rst_meta_ff;
        end
    end

    // One-second timebase
    always_ff @(posedge i_clk or negedge rstn_ff) begin
        if (!rstn_ff) begin
            pre_ff <= '0;
            tick_ff <= 1'b0;
        end else begin
            tick_ff <= (pre_ff == PRE_LAST);
            pre_ff <= (pre_ff == PRE_LAST) ? '0 : pre_ff + PW'(1);
        end
    end

    hpdft_press u_press (
        .i_clk(i_clk),
        .i_rstn(rstn_ff),
        .i_tick(tick_ff),
        .i_short(i_speedup_pins),
        .o_bypass(pin_bypass),
        .o_force(pin_force)
    );

    // Software command bits are self-clearing pulses
    always_ff @(posedge i_clk or negedge rstn_ff) begin
        if (!rstn_ff) begin
            sw_force_ff <= 1'b0;
            sw_bypass_ff <= 1'b0;
        end else begin
            sw_force_ff <= i_wr && i_addr == ADDR_CTRL && i_wdata[CTRL_FORCE_BIT];
            sw_bypass_ff <= i_wr && i_addr == ADDR_CTRL && i_wdata[CTRL_BYPASS_BIT];
        end
    end

    assign force_req = pin_force || sw_force_ff;
    assign bypass_req = pin_bypass || sw_bypass_ff;

    always_ff @(posedge i_clk or negedge rstn_ff) begin
        if (!rstn_ff) begin
            o_rdata <= '0;
        end else if (i_rd) begin
            unique case (i_addr)
                ADDR_STATUS: o_rdata <= {9'h000, i_coil_thermostat_input, short_ff,
                                         o_compressor, o_outdoor_fan_output, state_ff};
                ADDR_RUN: o_rdata <= DW'(run_ff);
                default: o_rdata <= '0;
            endcase
        end else begin
            o_rdata <= '0;
        end
    end

    always_comb begin
        unique case ({i_interval_select_hi, i_interval_select_lo})
            2'b01: interval = INT_A_S;
            2'b10: interval = INT_B_S;
            2'b00: interval = INT_C_S;
            2'b11: interval = INT_D_S;
        endcase
    end

    assign dfr_limit = short_ff ? SHORT_DFR_S : DFR_MAX_S;
    assign interval_due = (run_ff >= interval) && i_coil_thermostat_input;

    always_comb begin
        nxt_state = state_ff;
        nxt_short = short_ff;
        unique case (state_ff)
            ST_DELAY: begin
                if (bypass_req || tmr_ff >= START_DELAY_S) begin
                    nxt_state = ST_HEAT;
                end
            end
            ST_HEAT: begin
                if (force_req || interval_due) begin
                    // Forced with coil open runs only the short cycle
                    nxt_short = force_req && !i_coil_thermostat_input;
                    nxt_state = i_compressor_pause_switch ? ST_PRE : ST_DFR;
                end
            end
            ST_PRE: begin
                if (tmr_ff >= PAUSE_S) begin
                    nxt_state = ST_DFR;
                end
            end
            ST_DFR: begin
                if (tmr_ff >= dfr_limit || (!short_ff && !i_coil_thermostat_input)) begin
                    nxt_state = i_compressor_pause_switch ? ST_POST : ST_HEAT;
                end
            end
            ST_POST: begin
                if (tmr_ff >= PAUSE_S) begin
                    nxt_state = ST_HEAT;
                end
            end
            default: nxt_state = ST_DELAY;
        endcase
    end

    always_ff @(posedge i_clk or negedge rstn_ff) begin
        if (!rstn_ff) begin
            state_ff <= ST_DELAY;
            short_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            short_ff <= nxt_short;
        end
    end

    // Time in state; saturates so a long heat spell cannot wrap
    always_ff @(posedge i_clk or negedge rstn_ff) begin
        if (!rstn_ff) begin
            tmr_ff <= '0;
        end else if (nxt_state != state_ff) begin
            tmr_ff <= '0;
        end else if (tick_ff && tmr_ff != '1) begin
            tmr_ff <= tmr_ff + 14'h0001;
        end
    end

    // Heating run time counts only while the room calls for heat
    always_ff @(posedge i_clk or negedge rstn_ff) begin
        if (!rstn_ff) begin
            run_ff <= '0;
        end else if (state_ff == ST_DFR) begin
            run_ff <= '0;
        end else if (state_ff == ST_HEAT && i_heat_call && tick_ff && run_ff != '1) begin
            run_ff <= run_ff + 14'h0001;
        end
    end

    // Fan hold after a paused defrost
    always_ff @(posedge i_clk or negedge rstn_ff) begin
        if (!rstn_ff) begin
            fan_ff <= '0;
        end else if (state_ff == ST_DFR && nxt_state == ST_POST) begin
            fan_ff <= FAN_HOLD_S;
        end else if (tick_ff && fan_ff != '0) begin
            fan_ff <= fan_ff - 14'h0001;
        end
    end

    always_ff @(posedge i_clk or negedge rstn_ff) begin
        if (!rstn_ff) begin
            o_compressor <= 1'b0;
            o_outdoor_fan_output <= 1'b0;
            o_aux_heat_output <= 1'b0;
            o_reversing_valve <= 1'b0;
        end else begin
            // Pause and delay states keep the compressor off
            o_compressor <= i_heat_call && (state_ff == ST_HEAT || state_ff == ST_DFR);
            o_outdoor_fan_output <= i_heat_call && state_ff == ST_HEAT && fan_ff == '0;
            o_aux_heat_output <= state_ff == ST_DFR;
            o_reversing_valve <= state_ff == ST_DFR;
        end
    end

    sequence s_enter_dfr;
        state_ff == ST_HEAT && (force_req || interval_due);
    endsequence

    sequence s_dfr_done;
        state_ff == ST_DFR && (tmr_ff >= dfr_limit || (!short_ff && !i_coil_thermostat_input));
    endsequence

    AST_INTERVAL_MAP: assert property (
        !i_interval_select_hi && !i_interval_select_lo |-> interval == INT_C_S)
        else $error("Factory interval setting is wrong");

    AST_DFR_START: assert property (
        s_enter_dfr |=> (state_ff == ST_PRE) == i_compressor_pause_switch
            && (state_ff == ST_DFR) == !i_compressor_pause_switch)
        else $error("Defrost did not start on request");

    AST_FORCE_FULL: assert property (
        s_enter_dfr and i_coil_thermostat_input ##0 force_req |=> !short_ff)
        else $error("Forced defrost with coil closed was shortened");

    AST_PAUSE_COMP_OFF: assert property (
        state_ff == ST_PRE || state_ff == ST_POST |=> !o_compressor)
        else $error("Compressor ran during a pause");

    AST_SHORT_LIMIT: assert property (
        state_ff == ST_DFR && short_ff |-> tmr_ff <= SHORT_DFR_S)
        else $error("Short defrost overran");

    AST_FAN_HOLD: assert property (
        s_dfr_done ##0 i_compressor_pause_switch |=> fan_ff == FAN_HOLD_S ##1 !o_outdoor_fan_output)
        else $error("Fan hold not started after paused defrost");

    AST_DFR_END: assert property (
        s_dfr_done |=> state_ff != ST_DFR ##1 !o_aux_heat_output)
        else $error("Defrost did not end");

    AST_DFR_MAX: assert property (
        state_ff == ST_DFR |-> tmr_ff <= DFR_MAX_S)
        else $error("Defrost exceeded its limit");

    AST_DFR_OUTS: assert property (
        state_ff == ST_DFR |=> o_aux_heat_output && o_reversing_valve)
        else $error("Defrost outputs not energised");

    AST_NO_PAUSE: assert property (
        state_ff == ST_HEAT && nxt_state == ST_PRE |-> i_compressor_pause_switch)
        else $error("Pause taken with option off");

    AST_START_DELAY: assert property (
        state_ff == ST_DELAY |=> !o_compressor)
        else $error("Compressor ran in startup delay");

    AST_BYPASS: assert property (
        state_ff == ST_DELAY && bypass_req |=> state_ff == ST_HEAT)
        else $error("Delay bypass ignored");

    AST_DELAY_LEN: assert property (
        state_ff == ST_DELAY |-> tmr_ff <= START_DELAY_S)
        else $error("Startup delay overran");

    AST_PRE_LEN: assert property (
        state_ff == ST_PRE |-> tmr_ff <= PAUSE_S)
        else $error("Entry pause overran");

    AST_FAN_HELD: assert property (
        fan_ff != '0 |=> !o_outdoor_fan_output)
        else $error("Outdoor fan ran during its hold");

    AST_PLAIN_EXIT: assert property (
        s_dfr_done ##0 !i_compressor_pause_switch |=> state_ff == ST_HEAT)
        else $error("Compressor paused on leaving defrost with option off");
endmodule // hpdft_top
`default_nettype wire

// ### dv/hpdft_far.sv
// Purpose: Far-side model: coil thermostat, room heat call, speed-up pins
// Assumes: Bench clock; everything changes just after a rising edge
// Notes: Coil may reopen by itself after the valve has run melt cycles
`timescale 1ns/10ps
`default_nettype none
module hpdft_far #(
    parameter int TICK = 10
) (
    input wire logic i_clk,
    input wire logic i_reversing_valve,
    output logic o_coil,
    output logic o_call,
    output logic o_pins
);
    logic coil_cmd = 1'b0;
    logic call_cmd = 1'b1;
    int melt = 0;
    int warm;
    initial o_pins = 1'b0;
    always_ff @(posedge i_clk) begin
        warm <= i_reversing_valve ? warm + 1 : 0;
    end
    // Warmed coil opens on its own, so defrost can end slowly or promptly
    assign o_coil = coil_cmd && !(melt != 0 && warm >= melt);
    assign o_call = call_cmd;
    // Length of the short decides bypass or defrost request
    task automatic press(input int secs);
        @(posedge i_clk);
        o_pins <= 1'b1;
        repeat (secs * TICK) @(posedge i_clk);
        o_pins <= 1'b0;
    endtask
endmodule // hpdft_far
`default_nettype wire

// ### dv/hpdft_top_tb.sv
// Purpose: Self-checking bench for the defrost timer
// Assumes: One-second tick shortened to 10 cycles
// Notes: Durations allow one tick of phase jitter
`timescale 1ns/10ps
`default_nettype none
module hpdft_top_tb;
    import hpdft_pkg::*;
    localparam int TK = 10;
    localparam int C = 3;
    localparam int F = 2;
    localparam int A = 1;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic lo = 1'b0;
    logic hi = 1'b0;
    logic sw = 1'b0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [AW-1:0] addr = 2'h0;
    logic [DW-1:0] wdata = 16'h0000;
    logic [DW-1:0] rdata;
    logic coil, call, pins, comp, fan, aux, rev;
    logic [3:0] outs;
    logic [DW-1:0] d;
    int miscompares = 0;
    int n_compared = 0;
    int n;
    assign outs = {comp, fan, aux, rev};
    initial begin
        forever #20 clk = ~clk;
    end
    hpdft_top #(.TICK_CYCLES(TK)) DUT (
        .i_clk(clk), .i_rstn(rstn), .i_heat_call(call), .i_coil_thermostat_input(coil),
        .i_speedup_pins(pins), .i_interval_select_lo(lo), .i_interval_select_hi(hi),
        .i_compressor_pause_switch(sw), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
        .i_rd(rd), .o_rdata(rdata), .o_compressor(comp), .o_outdoor_fan_output(fan),
        .o_aux_heat_output(aux), .o_reversing_valve(rev));
    hpdft_far #(.TICK(TK)) far (.i_clk(clk), .i_reversing_valve(rev), .o_coil(coil),
        .o_call(call), .o_pins(pins));
    task automatic complete_run;
        if (miscompares == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input string what, input logic [DW-1:0] seen, input logic [DW-1:0] exp);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask
    function automatic logic [DW-1:0] win(input int v, input int lo_b, input int hi_b);
        return {15'h0000, v >= lo_b && v <= hi_b};
    endfunction
    // Bounded wait for one relay output to reach a level
    task automatic wait_out(input int idx, input logic val, input int lim, output int cnt);
        cnt = 0;
        while (outs[idx] !== val) begin
            @(posedge clk);
            #1;
            cnt++;
            if (cnt > lim) begin
                chk("relay output wait", {15'h0000, outs[idx]}, {15'h0000, val});
                complete_run();
            end
        end
    endtask
    task automatic reg_wr(input logic [AW-1:0] a, input logic [DW-1:0] v);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= v;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask
    task automatic reg_rd(input logic [AW-1:0] a, output logic [DW-1:0] v);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        v = rdata;
    endtask
    task automatic setin(input logic c, input logic l, input logic h, input logic s);
        @(posedge clk);
        far.coil_cmd <= c;
        lo <= l;
        hi <= h;
        sw <= s;
        #1;
    endtask
    task automatic s_startup;
        wait_out(C, 1'b1, 3100, n);
        chk("startup delay", win(n, 2980, 3020), 16'h0001);
        reg_rd(2'h3, d);
        chk("unmapped read", d, 16'h0000);
    endtask
    task automatic s_bypass;
        @(posedge clk);
        rstn <= 1'b0;
        repeat (20) @(posedge clk);
        #1;
        chk("outputs in reset", {12'h000, outs}, 16'h0000);
        @(posedge clk);
        rstn <= 1'b1;
        repeat (50) @(posedge clk);
        #1;
        chk("compressor in delay", {15'h0000, comp}, 16'h0000);
        far.press(2);
        #1;
        wait_out(C, 1'b1, 20, n);
    endtask
    task automatic s_forced;
        far.melt = 100;
        setin(1'b1, 1'b0, 1'b0, 1'b0);
        far.press(7);
        #1;
        wait_out(A, 1'b1, 20, n);
        chk("valve in defrost", {15'h0000, rev}, 16'h0001);
        reg_rd(ADDR_STATUS, d);
        chk("state in defrost", {13'h0000, d[2:0]}, 16'h0003);
        wait_out(A, 1'b0, 130, n);
        chk("end on coil open", win(n, 90, 106), 16'h0001);
        chk("valve after defrost", {15'h0000, rev}, 16'h0000);
        far.melt = 0;
    endtask
    task automatic s_cap;
        reg_wr(ADDR_CTRL, 16'h0001);
        wait_out(A, 1'b1, 10, n);
        wait_out(A, 1'b0, 6100, n);
        chk("defrost cap", win(n, 5980, 6020), 16'h0001);
    endtask
    task automatic s_pause_full;
        setin(1'b1, 1'b0, 1'b0, 1'b1);
        far.press(7);
        #1;
        wait_out(C, 1'b0, 20, n);
        wait_out(C, 1'b1, 330, n);
        chk("entry pause", win(n, 285, 315), 16'h0001);
        repeat (2) @(posedge clk);
        #1;
        chk("aux in defrost", {15'h0000, aux}, 16'h0001);
        setin(1'b0, 1'b0, 1'b0, 1'b1);
        wait_out(C, 1'b0, 5, n);
        wait_out(C, 1'b1, 330, n);
        chk("exit pause", win(n, 285, 315), 16'h0001);
        wait_out(F, 1'b1, 130, n);
    endtask
    task automatic s_short_pause;
        far.press(7);
        #1;
        wait_out(C, 1'b0, 20, n);
        wait_out(C, 1'b1, 330, n);
        chk("short pause", win(n, 285, 315), 16'h0001);
        wait_out(A, 1'b0, 330, n);
        chk("short defrost", win(n, 285, 315), 16'h0001);
        wait_out(C, 1'b0, 5, n);
        wait_out(C, 1'b1, 330, n);
        chk("return pause", win(n, 280, 315), 16'h0001);
        wait_out(F, 1'b1, 130, n);
        chk("fan hold", win(n, 85, 115), 16'h0001);
    endtask
    task automatic s_short_plain;
        setin(1'b0, 1'b0, 1'b0, 1'b0);
        far.press(7);
        #1;
        wait_out(A, 1'b1, 20, n);
        reg_rd(ADDR_STATUS, d);
        chk("short-cycle flag", {15'h0000, d[5]}, 16'h0001);
        wait_out(A, 1'b0, 330, n);
        chk("brief defrost", win(n, 285, 315), 16'h0001);
    endtask
    task automatic s_interval;
        setin(1'b0, 1'b0, 1'b1, 1'b0);
        repeat (18500) @(posedge clk);
        #1;
        reg_rd(ADDR_RUN, d);
        chk("run seconds", win(int'(d), 1845, 1852), 16'h0001);
        setin(1'b0, 1'b1, 1'b0, 1'b0);
        repeat (20) @(posedge clk);
        #1;
        chk("no defrost with coil open", {15'h0000, aux}, 16'h0000);
        setin(1'b1, 1'b0, 1'b1, 1'b0);
        repeat (20) @(posedge clk);
        #1;
        chk("no defrost at 60", {15'h0000, aux}, 16'h0000);
        setin(1'b1, 1'b1, 1'b1, 1'b0);
        repeat (20) @(posedge clk);
        #1;
        chk("no defrost at 120", {15'h0000, aux}, 16'h0000);
        setin(1'b1, 1'b0, 1'b0, 1'b0);
        repeat (20) @(posedge clk);
        #1;
        chk("no defrost at 90", {15'h0000, aux}, 16'h0000);
        setin(1'b1, 1'b1, 1'b0, 1'b0);
        wait_out(A, 1'b1, 20, n);
    endtask
    initial begin
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        #1;
        s_startup();
        s_bypass();
        s_forced();
        s_cap();
        s_pause_full();
        s_short_pause();
        s_short_plain();
        s_interval();
        complete_run();
    end
endmodule // hpdft_top_tb
`default_nettype wire
